//--- verilog/srwg_pkg.sv
/*
 package of the special register write guard: address map, reset values,
 field positions and shared decode functions.
 assumes a 32-bit peripheral address, byte wide data and one clock.
*/
// Contract
// - seven guarded registers in two groups
// - group a: five registers behind unlock a
// - group b: two registers behind unlock b
// - illegal guarded store raises protection error flag
// - software: prepare value, unlock, then guarded store
// - store or set/clear/invert bit op accepted
// - no interrupt taken while unlock is pending
// - guarded registers readable without unlock
// - five idle cycles after standby request
// - unlock data and address register match guarded store
// - error on unguarded store or stray store after unlock
// - reads between unlock and store keep unlock
// - error flag clears on reset or zero write
// - unlock registers byte wide, write-only, read undefined
package srwg_pkg;
   localparam int AW = 32;
   localparam int DW = 8;
   localparam int HW = 32;
   localparam int PROT_COUNT = 7;
   localparam logic [2:0] GROUP_A_COUNT = 3'h5;
   localparam logic [2:0] PROT_NONE = 3'h7;

   // bus operation kinds
   typedef enum logic [1:0] {
      SRWG_OP_STORE = 2'b00,
      SRWG_OP_SET = 2'b01,
      SRWG_OP_CLR = 2'b10,
      SRWG_OP_INV = 2'b11
   } srwg_op_type;

   // device address map
   localparam logic [AW-1:0] PERIPH_BASE = 32'hfffff000;
   localparam logic [AW-1:0] UNLOCK_A_ADDR = 32'hfffff1fc;
   localparam logic [AW-1:0] POWER_SAVE_ADDR = 32'hfffff1fe;
   localparam logic [AW-1:0] SYS_A_ADDR = 32'hfffff802;
   localparam logic [AW-1:0] CLOCK_SELECT_ADDR = 32'hfffff822;
   localparam logic [AW-1:0] CPU_CLOCK_ADDR = 32'hfffff828;
   localparam logic [AW-1:0] CLOCK_MONITOR_ADDR = 32'hfffff870;
   localparam logic [AW-1:0] RESET_CAUSE_ADDR = 32'hfffff888;
   localparam logic [AW-1:0] LOW_VOLTAGE_ADDR = 32'hfffff890;
   localparam logic [AW-1:0] RAM_STATUS_ADDR = 32'hfffff892;
   localparam logic [AW-1:0] SYS_B_ADDR = 32'hfffff8aa;
   localparam logic [AW-1:0] UNLOCK_B_ADDR = 32'hfffff9ec;
   localparam logic [AW-1:0] IRQ_STATUS_ADDR = 32'hfffff8b0;
   localparam logic [AW-1:0] IRQ_CLEAR_ADDR = 32'hfffff8b2;
   localparam logic [AW-1:0] IRQ_ENABLE_ADDR = 32'hfffff8b4;

   // reset values of the guarded registers, index order of prot_index
   localparam logic [PROT_COUNT-1:0][DW-1:0] PROT_RESET = {
      8'h01, 8'h00, 8'h00, 8'h00, 8'h03, 8'h0a, 8'h00};
   localparam logic [2:0] POWER_SAVE_IDX = 3'h0;
   localparam logic [2:0] RESET_CAUSE_IDX = 3'h4;

   // field positions
   localparam int ERR_BIT = 0;
   localparam int STANDBY_BIT = 1;
   localparam int NOP_COUNT = 5;
   localparam int IRQ_W = 3;
   localparam int IRQ_ERR_A = 0;
   localparam int IRQ_ERR_B = 1;
   localparam int IRQ_ACCEPT = 2;
   localparam logic [DW-1:0] BIT0 = 8'h01;

   // controller command port
   localparam logic [3:0] HOST_TARGET = 4'h0;
   localparam logic [3:0] HOST_DATA = 4'h1;
   localparam logic [3:0] HOST_CTRL = 4'h2;
   localparam logic [3:0] HOST_STATUS = 4'h3;
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_BIT_LSB = 2;
   localparam int CTRL_UNLOCK = 5;
   localparam int CTRL_READ = 6;
   localparam int STAT_BUSY = 0;
   localparam int STAT_DATA_LSB = 8;

   // index of a guarded register, PROT_NONE for any other address
   function automatic logic [2:0] prot_index(input logic [AW-1:0] addr);
      case (addr)
         POWER_SAVE_ADDR: prot_index = 3'h0;
         CLOCK_SELECT_ADDR: prot_index = 3'h1;
         CPU_CLOCK_ADDR: prot_index = 3'h2;
         CLOCK_MONITOR_ADDR: prot_index = 3'h3;
         RESET_CAUSE_ADDR: prot_index = 3'h4;
         LOW_VOLTAGE_ADDR: prot_index = 3'h5;
         RAM_STATUS_ADDR: prot_index = 3'h6;
         default: prot_index = PROT_NONE;
      endcase
   endfunction

   // unlock register that opens the group of an address
   function automatic logic [AW-1:0] unlock_for(input logic [AW-1:0] addr);
      unlock_for = (prot_index(addr) < GROUP_A_COUNT) ? UNLOCK_A_ADDR : UNLOCK_B_ADDR;
   endfunction

   // result of a store or bit operation on a byte
   function automatic logic [DW-1:0] apply_op(input logic [DW-1:0] old,
         input logic [DW-1:0] wdata, input srwg_op_type op, input logic [2:0] bitpos);
      case (op)
         SRWG_OP_SET: apply_op = old | (BIT0 << bitpos);
         SRWG_OP_CLR: apply_op = old & ~(BIT0 << bitpos);
         SRWG_OP_INV: apply_op = old ^ (BIT0 << bitpos);
         default: apply_op = wdata;
      endcase
   endfunction
endpackage

//--- verilog/srwg_bus_if.sv
/*
 peripheral bus between the cpu end and the write guard.
 assumes both ends run on i_mclk; strobes last one cycle, read data
 stand in the cycle after the read strobe.
*/
`timescale 1ns/1ps
interface srwg_bus_if;
   import srwg_pkg::*;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   srwg_op_type op;
   logic [2:0] bitpos;
   logic wr;
   logic rd;
   logic [DW-1:0] rdata;
   logic int_hold;

   // guard end
   modport dev (input addr, input wdata, input op, input bitpos, input wr, input rd,
      output rdata, output int_hold);
   // cpu end
   modport cpu (output addr, output wdata, output op, output bitpos, output wr,
      output rd, input rdata, input int_hold);
endinterface

//--- verilog/srwg_guard.sv
/*
 special register write guard: the seven guarded registers, the two
 unlock registers, both system status registers and an interrupt block.
 assumes bus inputs synchronous to i_mclk and one strobe per cycle.
*/
`timescale 1ns/1ps
module srwg_guard (
   input wire logic i_mclk,
   input wire logic i_srst,
   srwg_bus_if.dev bus,
   input wire logic [srwg_pkg::DW-1:0] i_reset_cause_set,
   output logic [srwg_pkg::PROT_COUNT-1:0][srwg_pkg::DW-1:0] o_protected,
   output logic o_err_a,
   output logic o_err_b,
   output logic o_irq
);
   import srwg_pkg::*;

   // register state
   logic [PROT_COUNT-1:0][DW-1:0] prot;
   logic pend_a;
   logic pend_b;
   logic err_a;
   logic err_b;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_en;
   logic irq;
   logic [DW-1:0] rdata;
   logic int_hold;

   // next values and decode
   logic [PROT_COUNT-1:0][DW-1:0] next_prot;
   logic next_pend_a;
   logic next_pend_b;
   logic next_err_a;
   logic next_err_b;
   logic [IRQ_W-1:0] next_irq_stat;
   logic [IRQ_W-1:0] next_irq_en;
   logic next_irq;
   logic [DW-1:0] next_rdata;
   logic next_int_hold;
   logic [2:0] idx;
   logic in_a;
   logic in_b;
   logic periph_wr;
   logic accept;
   logic ev_a;
   logic ev_b;
   logic [DW-1:0] sys_a_val;
   logic [DW-1:0] sys_b_val;
   logic [IRQ_W-1:0] irq_events;
   logic [IRQ_W-1:0] irq_clr;
   logic [DW-1:0] sys_a_new;
   logic [DW-1:0] sys_b_new;
   logic [DW-1:0] en_new;

   // address decode of the current access
   always_comb begin
      idx = prot_index(bus.addr);
      in_a = (idx < GROUP_A_COUNT);
      in_b = (idx != PROT_NONE) && !in_a;
      // ram and other off-window stores neither cancel nor use an unlock
      periph_wr = bus.wr && (bus.addr >= PERIPH_BASE);
   end

   // guard decisions for one write
   always_comb begin
      // a guarded store needs its own group's unlock on the previous write
      accept = periph_wr && ((in_a && pend_a) || (in_b && pend_b));
      // error: guarded store without unlock, or stray store after unlock
      ev_a = periph_wr && ((in_a && !pend_a) ||
         (pend_a && !in_a && (bus.addr != SYS_A_ADDR)));
      ev_b = periph_wr && ((in_b && !pend_b) ||
         (pend_b && !in_b && (bus.addr != SYS_B_ADDR)));
      sys_a_val = '0;
      sys_a_val[ERR_BIT] = err_a;
      sys_b_val = '0;
      sys_b_val[ERR_BIT] = err_b;
   end

   // guarded registers, unlock state and error flags
   always_comb begin
      next_prot = prot;
      next_pend_a = pend_a;
      next_pend_b = pend_b;
      next_err_a = err_a | ev_a;
      next_err_b = err_b | ev_b;
      // status bytes as a store or bit operation would leave them
      sys_a_new = apply_op(sys_a_val, bus.wdata, bus.op, bus.bitpos);
      sys_b_new = apply_op(sys_b_val, bus.wdata, bus.op, bus.bitpos);
      if (periph_wr) begin
         // any peripheral write uses up a pending unlock
         next_pend_a = (bus.addr == UNLOCK_A_ADDR);
         next_pend_b = (bus.addr == UNLOCK_B_ADDR);
         // a blocked store leaves the register as it was
         if (accept) begin
            next_prot[idx] = apply_op(prot[idx], bus.wdata, bus.op, bus.bitpos);
         end
         // a zero written to the flag wins even over detection
         if (bus.addr == SYS_A_ADDR) begin
            next_err_a = err_a & sys_a_new[ERR_BIT];
         end
         if (bus.addr == SYS_B_ADDR) begin
            next_err_b = err_b & sys_b_new[ERR_BIT];
         end
      end
      // hardware reset cause events win over a software write
      next_prot[RESET_CAUSE_IDX] = next_prot[RESET_CAUSE_IDX] | i_reset_cause_set;
      // interrupts stay held off while an unlock waits for its store
      next_int_hold = next_pend_a | next_pend_b;
   end

   // interrupt status, clear and enable
   always_comb begin
      irq_events = '0;
      irq_events[IRQ_ERR_A] = ev_a;
      irq_events[IRQ_ERR_B] = ev_b;
      irq_events[IRQ_ACCEPT] = accept;
      irq_clr = '0;
      en_new = apply_op({{(DW-IRQ_W){1'b0}}, irq_en}, bus.wdata, bus.op, bus.bitpos);
      next_irq_en = irq_en;
      if (periph_wr && (bus.addr == IRQ_CLEAR_ADDR)) begin
         irq_clr = bus.wdata[IRQ_W-1:0];
      end
      if (periph_wr && (bus.addr == IRQ_ENABLE_ADDR)) begin
         next_irq_en = en_new[IRQ_W-1:0];
      end
      // a new event wins over a clear in the same cycle
      next_irq_stat = (irq_stat & ~irq_clr) | irq_events;
      next_irq = |(next_irq_stat & next_irq_en);
   end

   // read data, one cycle after the strobe; reads need no unlock
   always_comb begin
      next_rdata = '0;
      if (bus.rd) begin
         if (idx != PROT_NONE) begin
            next_rdata = prot[idx];
         end else if (bus.addr == SYS_A_ADDR) begin
            next_rdata = sys_a_val;
         end else if (bus.addr == SYS_B_ADDR) begin
            next_rdata = sys_b_val;
         end else if (bus.addr == IRQ_STATUS_ADDR) begin
            next_rdata = {{(DW-IRQ_W){1'b0}}, irq_stat};
         end else if (bus.addr == IRQ_ENABLE_ADDR) begin
            next_rdata = {{(DW-IRQ_W){1'b0}}, irq_en};
         end else begin
            // unlock registers are write-only and read as zero here
            next_rdata = '0;
         end
      end
   end

   // state registers
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         prot <= PROT_RESET;
         pend_a <= 1'b0;
         pend_b <= 1'b0;
         err_a <= 1'b0;
         err_b <= 1'b0;
         irq_stat <= '0;
         irq_en <= '0;
         irq <= 1'b0;
         rdata <= '0;
         int_hold <= 1'b0;
      end else begin
         prot <= next_prot;
         pend_a <= next_pend_a;
         pend_b <= next_pend_b;
         err_a <= next_err_a;
         err_b <= next_err_b;
         irq_stat <= next_irq_stat;
         irq_en <= next_irq_en;
         irq <= next_irq;
         rdata <= next_rdata;
         int_hold <= next_int_hold;
      end
   end

   // outputs straight from the registers
   assign o_protected = prot;
   assign o_err_a = err_a;
   assign o_err_b = err_b;
   assign o_irq = irq;
   assign bus.rdata = rdata;
   assign bus.int_hold = int_hold;
endmodule

//--- verilog/srwg_cpu.sv
/*
 cpu end of the guarded bus: takes commands from software on a plain
 port and issues reads, plain stores and guarded unlock-store pairs.
 assumes the guard answers reads one cycle after the strobe.
*/
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module srwg_cpu (
   input wire logic i_mclk,
   input wire logic i_srst,
   srwg_bus_if.cpu bus,
   input wire logic [3:0] i_addr,
   input wire logic [srwg_pkg::HW-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [srwg_pkg::HW-1:0] o_rdata
);
   import srwg_pkg::*;

   typedef enum logic [2:0] {
      SRWG_IDLE = 3'b000,
      SRWG_UNLOCK = 3'b001,
      SRWG_RDWAIT = 3'b010,
      SRWG_NOP = 3'b011,
      SRWG_RDTAKE = 3'b100
   } srwg_state_type;

   srwg_state_type state;
   srwg_state_type next_state;
   logic [AW-1:0] target;
   logic [AW-1:0] next_target;
   logic [DW-1:0] data;
   logic [DW-1:0] next_data;
   srwg_op_type op;
   srwg_op_type next_op;
   logic [2:0] bitpos;
   logic [2:0] next_bitpos;
   logic [DW-1:0] read_val;
   logic [DW-1:0] next_read_val;
   logic [2:0] nop_cnt;
   logic [2:0] next_nop_cnt;
   logic [AW-1:0] b_addr;
   logic [AW-1:0] next_b_addr;
   logic [DW-1:0] b_wdata;
   logic [DW-1:0] next_b_wdata;
   srwg_op_type b_op;
   srwg_op_type next_b_op;
   logic [2:0] b_bitpos;
   logic [2:0] next_b_bitpos;
   logic b_wr;
   logic next_b_wr;
   logic b_rd;
   logic next_b_rd;
   logic [HW-1:0] rdata;
   logic [HW-1:0] next_rdata;
   logic standby;

   // a store that requests standby needs idle cycles afterwards
   always_comb begin
      standby = (prot_index(target) == POWER_SAVE_IDX) &&
         (((op == SRWG_OP_STORE) && data[STANDBY_BIT]) ||
         ((op == SRWG_OP_SET) && (bitpos == 3'(STANDBY_BIT))));
   end

   // command port and sequencer
   always_comb begin
      next_state = state;
      next_target = target;
      next_data = data;
      next_op = op;
      next_bitpos = bitpos;
      next_read_val = read_val;
      next_nop_cnt = nop_cnt;
      next_b_addr = b_addr;
      next_b_wdata = b_wdata;
      next_b_op = b_op;
      next_b_bitpos = b_bitpos;
      next_b_wr = 1'b0;
      next_b_rd = 1'b0;
      if (i_wr && (i_addr == HOST_TARGET)) begin
         next_target = i_wdata;
      end
      if (i_wr && (i_addr == HOST_DATA)) begin
         next_data = i_wdata[DW-1:0];
      end
      case (state)
         SRWG_IDLE: begin
            if (i_wr && (i_addr == HOST_CTRL)) begin
               next_op = srwg_op_type'(i_wdata[CTRL_OP_LSB +: 2]);
               next_bitpos = i_wdata[CTRL_BIT_LSB +: 3];
               next_b_wdata = data;
               next_b_op = SRWG_OP_STORE;
               next_b_bitpos = '0;
               if (i_wdata[CTRL_READ]) begin
                  next_b_addr = target;
                  next_b_rd = 1'b1;
                  next_state = SRWG_RDWAIT;
               end else if (i_wdata[CTRL_UNLOCK]) begin
                  // same value first to the unlock register
                  next_b_addr = unlock_for(target);
                  next_b_wr = 1'b1;
                  next_state = SRWG_UNLOCK;
               end else begin
                  next_b_addr = target;
                  next_b_op = srwg_op_type'(i_wdata[CTRL_OP_LSB +: 2]);
                  next_b_bitpos = i_wdata[CTRL_BIT_LSB +: 3];
                  next_b_wr = 1'b1;
               end
            end
         end
         SRWG_UNLOCK: begin
            // guarded store right after the unlock, nothing between
            next_b_addr = target;
            next_b_op = op;
            next_b_bitpos = bitpos;
            next_b_wr = 1'b1;
            next_nop_cnt = 3'(NOP_COUNT);
            next_state = standby ? SRWG_NOP : SRWG_IDLE;
         end
         // read data stand on the bus only in the cycle after the strobe
         SRWG_RDWAIT: begin
            next_state = SRWG_RDTAKE;
         end
         SRWG_RDTAKE: begin
            next_read_val = bus.rdata;
            next_state = SRWG_IDLE;
         end
         SRWG_NOP: begin
            next_nop_cnt = nop_cnt - 3'h1;
            if (nop_cnt == 3'h1) begin
               next_state = SRWG_IDLE;
            end
         end
         default: next_state = SRWG_IDLE;
      endcase
      next_rdata = '0;
      if (i_rd) begin
         case (i_addr)
            HOST_TARGET: next_rdata = target;
            HOST_DATA: next_rdata = {{(HW-DW){1'b0}}, data};
            HOST_STATUS: begin
               next_rdata[STAT_BUSY] = (state != SRWG_IDLE);
               next_rdata[STAT_DATA_LSB +: DW] = read_val;
            end
            default: next_rdata = '0;
         endcase
      end
   end

   // registers
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         state <= SRWG_IDLE;
         target <= '0;
         data <= '0;
         op <= SRWG_OP_STORE;
         bitpos <= '0;
         read_val <= '0;
         nop_cnt <= '0;
         b_addr <= '0;
         b_wdata <= '0;
         b_op <= SRWG_OP_STORE;
         b_bitpos <= '0;
         b_wr <= 1'b0;
         b_rd <= 1'b0;
         rdata <= '0;
      end else begin
         state <= next_state;
         target <= next_target;
         data <= next_data;
         op <= next_op;
         bitpos <= next_bitpos;
         read_val <= next_read_val;
         nop_cnt <= next_nop_cnt;
         b_addr <= next_b_addr;
         b_wdata <= next_b_wdata;
         b_op <= next_b_op;
         b_bitpos <= next_b_bitpos;
         b_wr <= next_b_wr;
         b_rd <= next_b_rd;
         rdata <= next_rdata;
      end
   end

   // bus drive from the registers
   assign bus.addr = b_addr;
   assign bus.wdata = b_wdata;
   assign bus.op = b_op;
   assign bus.bitpos = b_bitpos;
   assign bus.wr = b_wr;
   assign bus.rd = b_rd;
   assign o_rdata = rdata;
endmodule

//--- tb/srwg_guard_properties.sv
/*
 concurrent checks on the peripheral bus between the cpu end and the guard.
 assumes one clock i_mclk and synchronous active-high reset i_srst.
*/
`timescale 1ns/1ps
module srwg_guard_properties (
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic [srwg_pkg::AW-1:0] addr,
   input wire logic [srwg_pkg::DW-1:0] wdata,
   input wire srwg_pkg::srwg_op_type op,
   input wire logic [2:0] bitpos,
   input wire logic wr,
   input wire logic rd,
   input wire logic [srwg_pkg::DW-1:0] rdata,
   input wire logic int_hold
);
   import srwg_pkg::*;

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_srst);

   // the bus steps of an unlock sequence
   sequence unlock_wr_s;
      wr && (addr == UNLOCK_A_ADDR || addr == UNLOCK_B_ADDR);
   endsequence
   sequence unlock_rd_s;
      rd && (addr == UNLOCK_A_ADDR || addr == UNLOCK_B_ADDR);
   endsequence
   sequence periph_wr_s;
      wr && addr >= PERIPH_BASE && addr != UNLOCK_A_ADDR && addr != UNLOCK_B_ADDR;
   endsequence

   hold_set_a: assert property (unlock_wr_s |=> int_hold)
      else $error("interrupt hold missing after unlock write");
   hold_cause_a: assert property ($rose(int_hold) |-> $past(wr) &&
      ($past(addr) == UNLOCK_A_ADDR || $past(addr) == UNLOCK_B_ADDR))
      else $error("interrupt hold raised without unlock write");
   one_write_a: assert property (int_hold ##0 periph_wr_s |=> !int_hold)
      else $error("unlock still pending after the next write");
   pair_next_a: assert property (unlock_wr_s |=> periph_wr_s)
      else $error("unlock write not followed by the target store");
   same_data_a: assert property (unlock_wr_s |=> $stable(wdata))
      else $error("unlock data differs from target store data");
   unlock_read_a: assert property (unlock_rd_s |=> rdata == '0)
      else $error("unlock register read returned data");
   rdata_idle_a: assert property (!rd |=> rdata == '0)
      else $error("read data driven without a read");
   strobe_excl_a: assert property (!(wr && rd))
      else $error("read and write strobes together");
endmodule

//--- tb/srwg_guard_tb.sv
/*
 testbench of the write guard: cpu end and guard joined by the bus interface,
 software side driven through the cpu command port.
 assumes 100 MHz i_mclk and the register map of srwg_pkg.
*/
`timescale 1ns/1ps
module srwg_guard_tb;
   import srwg_pkg::*;
   logic i_mclk = 1'b0;
   logic i_srst = 1'b1;
   logic [3:0] i_addr = 4'h0;
   logic [HW-1:0] i_wdata = '0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [HW-1:0] o_rdata;
   logic [DW-1:0] i_reset_cause_set = 8'h00;
   logic [PROT_COUNT-1:0][DW-1:0] o_protected;
   logic o_err_a;
   logic o_err_b;
   logic o_irq;
   int fails = 0;
   int checks = 0;
   int seed = 53400;
   logic [DW-1:0] exp_prot [PROT_COUNT];
   logic [1:0] exp_err;
   localparam logic [AW-1:0] GUARD_ADDR [PROT_COUNT] = '{POWER_SAVE_ADDR, CLOCK_SELECT_ADDR,
      CPU_CLOCK_ADDR, CLOCK_MONITOR_ADDR, RESET_CAUSE_ADDR, LOW_VOLTAGE_ADDR, RAM_STATUS_ADDR};

   // clock of 10 ns period
   always #5 i_mclk = ~i_mclk;

   // both ends joined through the bus interface
   srwg_bus_if srwg_bus_if_i ();
   srwg_guard srwg_guard_i (.i_mclk(i_mclk), .i_srst(i_srst), .bus(srwg_bus_if_i.dev),
      .i_reset_cause_set(i_reset_cause_set), .o_protected(o_protected), .o_err_a(o_err_a),
      .o_err_b(o_err_b), .o_irq(o_irq));
   srwg_cpu srwg_cpu_i (.i_mclk(i_mclk), .i_srst(i_srst), .bus(srwg_bus_if_i.cpu),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
   srwg_guard_properties srwg_guard_properties_i (.i_mclk(i_mclk), .i_srst(i_srst),
      .addr(srwg_bus_if_i.addr), .wdata(srwg_bus_if_i.wdata), .op(srwg_bus_if_i.op),
      .bitpos(srwg_bus_if_i.bitpos), .wr(srwg_bus_if_i.wr), .rd(srwg_bus_if_i.rd),
      .rdata(srwg_bus_if_i.rdata), .int_hold(srwg_bus_if_i.int_hold));

   // verdict and end of run
   task automatic test_done();
      if (fails == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // compares one value and reports a mismatch
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one-cycle strobes on the command port
   task automatic host_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask
   task automatic host_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask

   // one bus operation through the cpu end, waiting while busy
   task automatic dev_op(input logic [AW-1:0] tgt, input logic [7:0] d, input logic [7:0] ctrl);
      logic [31:0] s;
      host_wr(HOST_TARGET, tgt);
      host_wr(HOST_DATA, {24'h0, d});
      host_wr(HOST_CTRL, {24'h0, ctrl});
      for (int k = 0; k < 20; k++) begin
         host_rd(HOST_STATUS, s);
         if (s[STAT_BUSY] === 1'b0) break;
      end
      check("cpu_busy", {31'h0, s[STAT_BUSY]}, 32'h0);
   endtask
   task automatic dev_rd(input logic [AW-1:0] tgt, output logic [7:0] v);
      logic [31:0] s;
      dev_op(tgt, 8'h00, 8'h40);
      host_rd(HOST_STATUS, s);
      v = s[STAT_DATA_LSB +: 8];
   endtask

   // expected result of a store or bit operation
   function automatic logic [7:0] model_op(input logic [7:0] old, input logic [7:0] d,
         input logic [1:0] op, input logic [2:0] b);
      case (op)
         2'h1: return old | (8'h01 << b);
         2'h2: return old & ~(8'h01 << b);
         2'h3: return old ^ (8'h01 << b);
         default: return d;
      endcase
   endfunction

   // guarded write with or without unlock, and the expected outcome
   task automatic guarded(input int idx, input logic [7:0] d, input logic [1:0] op,
         input logic [2:0] b, input logic unl);
      dev_op(GUARD_ADDR[idx], d, {2'b00, unl, b, op});
      if (unl) begin
         exp_prot[idx] = model_op(exp_prot[idx], d, op, b);
      end else begin
         exp_err[idx >= 5] = 1'b1;
      end
   endtask

   // compares every guarded register and both error flags
   task automatic check_state();
      for (int i = 0; i < PROT_COUNT; i++) begin
         check("protected", o_protected[i], exp_prot[i]);
      end
      check("err_a", o_err_a, exp_err[0]);
      check("err_b", o_err_b, exp_err[1]);
   endtask
   task automatic read_all();
      logic [7:0] v;
      for (int i = 0; i < PROT_COUNT; i++) begin
         dev_rd(GUARD_ADDR[i], v);
         check("read_back", v, exp_prot[i]);
      end
   endtask
   task automatic init_exp();
      for (int i = 0; i < PROT_COUNT; i++) exp_prot[i] = PROT_RESET[i];
      exp_err = 2'b00;
   endtask

   // main sequence
   initial begin
      logic [7:0] v;
      logic [31:0] s;
      int idx;
      repeat (2) @(posedge i_mclk);
      i_srst <= 1'b0;
      @(posedge i_mclk);
      #1 init_exp();
      check_state();
      read_all();
      // blocked writes in each group, then clearing the flags
      guarded(1, 8'h55, 2'h0, 3'h0, 1'b0);
      guarded(6, 8'h55, 2'h0, 3'h0, 1'b0);
      check_state();
      dev_op(SYS_A_ADDR, 8'h01, 8'h00);
      check("err_a_one", o_err_a, 1'b1);
      dev_op(SYS_A_ADDR, 8'h00, 8'h00);
      dev_op(SYS_B_ADDR, 8'h00, 8'h20);
      exp_err = 2'b00;
      check_state();
      // stray store right after an unlock
      dev_op(IRQ_ENABLE_ADDR, 8'h00, 8'h20);
      exp_err[1] = 1'b1;
      check_state();
      // interrupt raised, masked, unmasked and cleared
      dev_op(IRQ_CLEAR_ADDR, 8'h07, 8'h00);
      dev_op(IRQ_ENABLE_ADDR, 8'h01, 8'h00);
      check("irq_idle", o_irq, 1'b0);
      guarded(2, 8'hff, 2'h0, 3'h0, 1'b0);
      check("irq_set", o_irq, 1'b1);
      dev_rd(IRQ_STATUS_ADDR, v);
      check("irq_status", v, 8'h01);
      dev_op(IRQ_ENABLE_ADDR, 8'h00, 8'h00);
      check("irq_masked", o_irq, 1'b0);
      dev_op(IRQ_ENABLE_ADDR, 8'h01, 8'h00);
      check("irq_unmask", o_irq, 1'b1);
      dev_op(IRQ_CLEAR_ADDR, 8'h01, 8'h00);
      check("irq_clear", o_irq, 1'b0);
      dev_rd(IRQ_ENABLE_ADDR, v);
      check("irq_enable", v, 8'h01);
      // unlock registers and an unmapped place read as zero
      dev_rd(UNLOCK_A_ADDR, v);
      check("unlock_a_rd", v, 8'h00);
      dev_rd(UNLOCK_B_ADDR, v);
      check("unlock_b_rd", v, 8'h00);
      dev_rd(32'hfffff004, v);
      check("unmapped_rd", v, 8'h00);
      // reset cause set from outside, then cleared by a guarded bit clear
      @(posedge i_mclk);
      i_reset_cause_set <= 8'h10;
      @(posedge i_mclk);
      i_reset_cause_set <= 8'h00;
      exp_prot[4] = exp_prot[4] | 8'h10;
      guarded(4, 8'h00, 2'h2, 3'h4, 1'b1);
      check_state();
      // standby request keeps the cpu end busy for the nop cycles
      host_wr(HOST_TARGET, POWER_SAVE_ADDR);
      host_wr(HOST_DATA, 32'h02);
      host_wr(HOST_CTRL, 32'h20);
      host_rd(HOST_STATUS, s);
      check("standby_busy", {31'h0, s[STAT_BUSY]}, 32'h1);
      repeat (3) host_rd(HOST_STATUS, s);
      check("standby_done", {31'h0, s[STAT_BUSY]}, 32'h0);
      exp_prot[0] = 8'h02;
      check_state();
      // random traffic, every operation kind in turn
      for (int k = 0; k < 40; k++) begin
         idx = ($random(seed) & 32'h7fffffff) % PROT_COUNT;
         guarded(idx, 8'($random(seed)), 2'(k), 3'($random(seed)), ($random(seed) & 3) != 0);
         check_state();
      end
      read_all();
      // second reset in mid-run
      @(posedge i_mclk);
      i_srst <= 1'b1;
      repeat (2) @(posedge i_mclk);
      i_srst <= 1'b0;
      @(posedge i_mclk);
      #1 init_exp();
      check_state();
      check("irq_reset", o_irq, 1'b0);
      test_done();
   end

   // watchdog against a hung handshake
   initial begin
      #200000;
      fails++;
      test_done();
   end
endmodule
